// >>> rtl/asc_core.sv
// Asynchronous serial transmitter and receiver core with an APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"

module asc_core (
    input  wire logic        mclk_in,      // Bus clock, 100 MHz
    input  wire logic        nrst_in,      // Synchronous reset, active low
    input  wire logic        psel_in,      // APB select
    input  wire logic        penable_in,   // APB access phase
    input  wire logic        pwrite_in,    // APB direction, high for write
    input  wire logic [7:0]  paddr_in,     // APB byte address
    input  wire logic [31:0] pwdata_in,    // APB write data
    output logic      [31:0] prdata_out,   // APB read data
    output logic             pready_out,   // APB ready
    output logic             pslverr_out,  // APB error on unmapped address
    input  wire logic        rx_pin_in,    // Serial receive line
    output logic             tx_pin_out,   // Serial transmit line
    output logic             tx_drive_out  // High while transmitter owns the pin
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    asc_pkg::asc_cfg_s cfg_ff;
    asc_pkg::asc_ctl_s ctl_ff;
    asc_pkg::asc_sts_s sts_ff;
    asc_pkg::asc_rx_e  rx_st_ff;
    logic [12:0] baud_div_ff, baud_cnt_ff;
    logic [10:0] tx_shift_ff;
    logic [8:0]  tx_buf_ff, rx_shift_ff, rx_buf_ff;
    logic [7:0]  idle_cnt_ff, idle_thr;
    logic [3:0]  tx_sub_ff, tx_left_ff, rt_ff, bit_idx_ff, rt_cur, last_bit;
    logic [2:0]  hist_ff;
    logic [1:0]  vote_ff, zeros;
    logic        tick_ff, tx_fill_ff, idle_pend_ff, brk_pend_ff, tx_on_d_ff, brk_req_d_ff;
    logic        rx_s1_ff, rx_s2_ff, nz_ff, any_one_ff, idle_arm_ff, clr_arm_ff;
    logic        acc, wr_hit, rd_hit, mapped, tx_tick, smp, edge_seen, maj, bit_done;
    logic        stop_done, mark_wake, idle_evt, rx_load, rx_ovr, brk_char;
    logic [31:0] nxt_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode: one setup cycle, answer in the first access cycle
    assign acc    = psel_in && penable_in && pready_out;
    assign wr_hit = acc && pwrite_in;
    assign rd_hit = acc && !pwrite_in;
    assign mapped = (paddr_in == `ASC_OFF_CTRL_ONE) || (paddr_in == `ASC_OFF_CTRL_TWO) ||
                    (paddr_in == `ASC_OFF_STATUS_ONE) || (paddr_in == `ASC_OFF_DATA_PORT) ||
                    (paddr_in == `ASC_OFF_BAUD_DIV);

    // Read data mux, unmapped reads as zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (paddr_in)
            `ASC_OFF_CTRL_ONE: begin
                nxt_rdata[5:0]               = cfg_ff;
                nxt_rdata[`ASC_BIT_RX_NINTH] = rx_buf_ff[8];
            end
            `ASC_OFF_CTRL_TWO:   nxt_rdata[3:0] = ctl_ff;
            `ASC_OFF_STATUS_ONE: begin
                nxt_rdata[6:0]                = sts_ff;
                nxt_rdata[`ASC_BIT_RX_ACTIVE] = (rx_st_ff != asc_pkg::ASC_RX_HUNT);
            end
            `ASC_OFF_DATA_PORT:  nxt_rdata[8:0]  = rx_buf_ff;
            `ASC_OFF_BAUD_DIV:   nxt_rdata[12:0] = baud_div_ff;
            default:             nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Bus answer registers
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !mapped;
            prdata_out  <= nxt_rdata;
        end
    end

    // Configuration and control writes; hardware clears sleep on wakeup
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            cfg_ff      <= `ASC_RST_CTRL_ONE;
            ctl_ff      <= `ASC_RST_CTRL_TWO;
            baud_div_ff <= `ASC_RST_BAUD_DIV;
        end else begin
            if (mark_wake || (idle_evt && !cfg_ff.wake_sel && ctl_ff.rx_sleep)) begin
                ctl_ff.rx_sleep <= 1'b0;
            end
            if (wr_hit && paddr_in == `ASC_OFF_CTRL_ONE) cfg_ff <= pwdata_in[5:0];
            if (wr_hit && paddr_in == `ASC_OFF_CTRL_TWO) ctl_ff <= pwdata_in[3:0];
            if (wr_hit && paddr_in == `ASC_OFF_BAUD_DIV) baud_div_ff <= pwdata_in[12:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Baud divider: 16x sample tick, transmit bit on every sixteenth tick
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            baud_cnt_ff <= 13'h0000;
            tick_ff     <= 1'b0;
            tx_sub_ff   <= 4'h0;
        end else begin
            tick_ff <= (baud_cnt_ff >= baud_div_ff);
            baud_cnt_ff <= (baud_cnt_ff >= baud_div_ff) ? 13'h0000 : baud_cnt_ff + 13'h0001;
            if (tick_ff) tx_sub_ff <= tx_sub_ff + 4'h1;
        end
    end
    assign tx_tick = tick_ff && (tx_sub_ff == `ASC_TICKS_PER_BIT);

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer and queued idle/break requests
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            tx_buf_ff    <= 9'h000;
            idle_pend_ff <= 1'b0;
            brk_pend_ff  <= 1'b0;
            tx_on_d_ff   <= 1'b0;
            brk_req_d_ff <= 1'b0;
        end else begin
            tx_on_d_ff   <= ctl_ff.tx_on;
            brk_req_d_ff <= ctl_ff.break_request;
            if (tx_tick && tx_left_ff <= 4'h1) begin
                if (idle_pend_ff) idle_pend_ff <= 1'b0;
                else if (brk_pend_ff) brk_pend_ff <= ctl_ff.break_request;
            end
            if (ctl_ff.tx_on && !tx_on_d_ff) idle_pend_ff <= 1'b1;
            if (!ctl_ff.break_request && brk_req_d_ff) brk_pend_ff <= 1'b1;
            if (wr_hit && paddr_in == `ASC_OFF_DATA_PORT) begin
                tx_buf_ff <= {cfg_ff.ninth_tx_bit, pwdata_in[7:0]};
            end
        end
    end

    // Transmit shifter: idle frames first, then breaks, then data
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            tx_shift_ff <= 11'h7ff;
            tx_fill_ff  <= 1'b1;
            tx_left_ff  <= 4'h0;
        end else if (tx_tick) begin
            if (tx_left_ff > 4'h1) begin
                tx_shift_ff <= {tx_fill_ff, tx_shift_ff[10:1]};
                tx_left_ff  <= tx_left_ff - 4'h1;
            end else if (idle_pend_ff) begin
                tx_shift_ff <= 11'h7ff;
                tx_fill_ff  <= 1'b1;
                tx_left_ff  <= cfg_ff.mode9 ? `ASC_FRAME_BITS_9 : `ASC_FRAME_BITS_8;
            end else if (brk_pend_ff) begin
                tx_shift_ff <= 11'h000;
                tx_fill_ff  <= 1'b0;
                case ({cfg_ff.long_break_select, cfg_ff.mode9})
                    2'b00:   tx_left_ff <= `ASC_FRAME_BITS_8;
                    2'b01:   tx_left_ff <= `ASC_FRAME_BITS_9;
                    2'b10:   tx_left_ff <= `ASC_BREAK_BITS_13;
                    default: tx_left_ff <= `ASC_BREAK_BITS_14;
                endcase
            end else if (ctl_ff.tx_on && !sts_ff.tx_empty_flag) begin
                // Start, LSB-first data, optional ninth bit, stop
                tx_shift_ff <= cfg_ff.mode9 ? {1'b1, tx_buf_ff, 1'b0}
                                            : {2'b11, tx_buf_ff[7:0], 1'b0};
                tx_fill_ff  <= 1'b1;
                tx_left_ff  <= cfg_ff.mode9 ? `ASC_FRAME_BITS_9 : `ASC_FRAME_BITS_8;
            end else begin
                tx_shift_ff <= 11'h7ff;
                tx_fill_ff  <= 1'b1;
                tx_left_ff  <= 4'h0;
            end
        end
    end

    // Line drive: idle high, inverted by polarity flip; pin held until work ends
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            tx_pin_out   <= 1'b1;
            tx_drive_out <= 1'b0;
        end else begin
            tx_pin_out   <= ((tx_left_ff != 4'h0) ? tx_shift_ff[0] : 1'b1)
                            ^ cfg_ff.tx_polarity_flip;
            tx_drive_out <= ctl_ff.tx_on || (tx_left_ff != 4'h0) ||
                            idle_pend_ff || brk_pend_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive input synchroniser and per-tick sampling terms
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
        end else begin
            rx_s1_ff <= rx_pin_in;
            rx_s2_ff <= rx_s1_ff;
        end
    end

    assign smp       = rx_s2_ff;
    assign rt_cur    = rt_ff + 4'h1;  // Slot of this sample, 0 stands for RT16
    assign edge_seen = tick_ff && !smp && (hist_ff == 3'b111);
    assign last_bit  = cfg_ff.mode9 ? 4'ha : 4'h9;
    assign zeros     = {1'b0, !vote_ff[0]} + {1'b0, !vote_ff[1]};
    assign maj       = (vote_ff[0] && vote_ff[1]) || (smp && (vote_ff[0] || vote_ff[1]));
    assign bit_done  = tick_ff && (rx_st_ff == asc_pkg::ASC_RX_BITS) && (rt_cur == 4'ha);
    assign stop_done = bit_done && (bit_idx_ff == last_bit);
    assign mark_wake = bit_done && (bit_idx_ff == last_bit - 4'h1) && maj &&
                       cfg_ff.wake_sel && ctl_ff.rx_sleep;
    assign brk_char  = !any_one_ff && !maj;
    assign rx_load   = stop_done && !ctl_ff.rx_sleep && !sts_ff.framing_error_flag &&
                       !sts_ff.rx_full_flag;
    assign rx_ovr    = stop_done && !ctl_ff.rx_sleep && !sts_ff.framing_error_flag &&
                       sts_ff.rx_full_flag;
    assign idle_thr  = cfg_ff.mode9 ? `ASC_IDLE_TICKS_9 : `ASC_IDLE_TICKS_8;
    assign idle_evt  = tick_ff && smp && (idle_cnt_ff == idle_thr - 8'h01);

    // Edge-search history, preloaded with ones after a non-break framing error
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            hist_ff <= 3'b000;
        end else if (stop_done && !maj && !brk_char) begin
            hist_ff <= 3'b111;
        end else if (tick_ff) begin
            hist_ff <= {hist_ff[1:0], smp};
        end
    end

    // Receive sequencer: start check, bit voting, realignment on edges
    always_ff @(posedge mclk_in) begin
        if (!nrst_in || !ctl_ff.rx_on) begin
            rx_st_ff    <= asc_pkg::ASC_RX_HUNT;
            rt_ff       <= 4'h0;
            bit_idx_ff  <= 4'h0;
            vote_ff     <= 2'b11;
            nz_ff       <= 1'b0;
            any_one_ff  <= 1'b0;
            rx_shift_ff <= 9'h000;
        end else if (tick_ff) begin
            rt_ff <= rt_cur;
            case (rx_st_ff)
                asc_pkg::ASC_RX_HUNT: begin
                    if (edge_seen) begin
                        rx_st_ff   <= asc_pkg::ASC_RX_START;
                        rt_ff      <= 4'h1;
                        bit_idx_ff <= 4'h0;
                        vote_ff    <= 2'b11;
                        nz_ff      <= 1'b0;
                        any_one_ff <= 1'b0;
                    end
                end
                asc_pkg::ASC_RX_START: begin
                    if (rt_cur == 4'h3) vote_ff[0] <= smp;
                    if (rt_cur == 4'h5) vote_ff[1] <= smp;
                    if (rt_cur == 4'h7) begin
                        if (zeros + {1'b0, !smp} < 2'h2) begin
                            rx_st_ff <= asc_pkg::ASC_RX_HUNT;
                        end
                    end
                    if (rt_cur == 4'h3 || rt_cur == 4'h5 || rt_cur == 4'h7 ||
                        rt_cur == 4'h8 || rt_cur == 4'h9 || rt_cur == 4'ha) begin
                        if (smp) nz_ff <= 1'b1;
                    end
                    if (rt_cur == 4'h0) begin
                        rx_st_ff   <= asc_pkg::ASC_RX_BITS;
                        bit_idx_ff <= 4'h1;
                    end
                end
                asc_pkg::ASC_RX_BITS: begin
                    if (rt_cur == 4'h8) vote_ff[0] <= smp;
                    if (rt_cur == 4'h9) vote_ff[1] <= smp;
                    if (rt_cur == 4'ha) begin
                        if (!(vote_ff[0] == smp && vote_ff[1] == smp)) begin
                            nz_ff <= 1'b1;
                        end
                        if (bit_idx_ff != last_bit) begin
                            rx_shift_ff <= cfg_ff.mode9 ? {maj, rx_shift_ff[8:1]}
                                                        : {1'b0, maj, rx_shift_ff[7:1]};
                            if (maj) any_one_ff <= 1'b1;
                        end else begin
                            rx_st_ff <= asc_pkg::ASC_RX_HUNT;
                        end
                    end
                    if (edge_seen) begin
                        rt_ff <= 4'h1;
                        if (rt_cur >= 4'hb || rt_cur == 4'h0) begin
                            bit_idx_ff <= bit_idx_ff + 4'h1;
                        end
                    end else if (rt_cur == 4'h0) begin
                        bit_idx_ff <= bit_idx_ff + 4'h1;
                    end
                end
                default: rx_st_ff <= asc_pkg::ASC_RX_HUNT;
            endcase
        end
    end

    // Idle-line counter, started after the start bit or after the stop bit
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            idle_cnt_ff <= 8'h00;
        end else if (tick_ff) begin
            if (!smp) begin
                idle_cnt_ff <= 8'h00;
            end else if (idle_cnt_ff != idle_thr &&
                         (rx_st_ff == asc_pkg::ASC_RX_HUNT ||
                          (!cfg_ff.idle_count_start && rx_st_ff == asc_pkg::ASC_RX_BITS))) begin
                idle_cnt_ff <= idle_cnt_ff + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive buffer
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            rx_buf_ff <= 9'h000;
        end else if (rx_load) begin
            rx_buf_ff <= rx_shift_ff;
        end
    end

    // Flag clearing sequence: status read arms, data read completes, data write disarms without clearing
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            clr_arm_ff <= 1'b0;
        end else if (rd_hit && paddr_in == `ASC_OFF_STATUS_ONE && sts_ff[6:2] != 5'h00) begin
            clr_arm_ff <= 1'b1;
        end else if (acc && paddr_in == `ASC_OFF_DATA_PORT) begin
            clr_arm_ff <= 1'b0;
        end
    end

    // Status flags; a hardware set in the read-clearing cycle wins, but a data write clears the transmit flags over a hardware set
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            sts_ff      <= 7'h03;
            idle_arm_ff <= 1'b0;
        end else begin
            if (rd_hit && paddr_in == `ASC_OFF_DATA_PORT && clr_arm_ff) begin
                sts_ff.rx_full_flag       <= 1'b0;
                sts_ff.idle_flag          <= 1'b0;
                sts_ff.overrun_flag       <= 1'b0;
                sts_ff.noise_flag         <= 1'b0;
                sts_ff.framing_error_flag <= 1'b0;
            end
            if (tx_tick && tx_left_ff <= 4'h1 && !idle_pend_ff && !brk_pend_ff &&
                ctl_ff.tx_on && !sts_ff.tx_empty_flag) begin
                sts_ff.tx_empty_flag    <= 1'b1;
                sts_ff.tx_complete_flag <= 1'b0;
            end else if (tx_tick && tx_left_ff <= 4'h1 && (idle_pend_ff || brk_pend_ff)) begin
                sts_ff.tx_complete_flag <= 1'b0;
            end else if (tx_tick && tx_left_ff == 4'h1) begin
                sts_ff.tx_complete_flag <= 1'b1;
            end
            if (wr_hit && paddr_in == `ASC_OFF_DATA_PORT) begin
                sts_ff.tx_empty_flag    <= 1'b0;
                sts_ff.tx_complete_flag <= 1'b0;
            end
            if (rx_load) begin
                sts_ff.rx_full_flag       <= 1'b1;
                sts_ff.noise_flag         <= nz_ff || !(vote_ff[0] == smp && vote_ff[1] == smp);
                sts_ff.framing_error_flag <= !maj;
                idle_arm_ff               <= 1'b1;
            end
            if (rx_ovr) sts_ff.overrun_flag <= 1'b1;
            if (idle_evt && !ctl_ff.rx_sleep && idle_arm_ff) begin
                sts_ff.idle_flag <= 1'b1;
                idle_arm_ff      <= 1'b0;
            end
        end
    end

endmodule : asc_core
`default_nettype wire

// >>> rtl/asc_regs.svh
// Register offsets, field positions, reset values and timing counts of the serial core
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_OFF_CTRL_ONE   8'h00
`define ASC_OFF_CTRL_TWO   8'h04
`define ASC_OFF_STATUS_ONE 8'h08
`define ASC_OFF_DATA_PORT  8'h0c
`define ASC_OFF_BAUD_DIV   8'h10
`define ASC_RST_CTRL_ONE   6'h00
`define ASC_RST_CTRL_TWO   4'h0
`define ASC_RST_BAUD_DIV   13'h0036
`define ASC_BIT_RX_NINTH   6
`define ASC_BIT_RX_ACTIVE  7
`define ASC_TICKS_PER_BIT  4'hf
`define ASC_FRAME_BITS_8   4'ha
`define ASC_FRAME_BITS_9   4'hb
`define ASC_BREAK_BITS_13  4'hd
`define ASC_BREAK_BITS_14  4'he
`define ASC_IDLE_TICKS_8   8'ha0
`define ASC_IDLE_TICKS_9   8'hb0
`endif

// >>> rtl/asc_pkg.sv
// Types shared by the serial core
package asc_pkg;
    // Line format and wakeup configuration
    typedef struct packed {
        logic ninth_tx_bit;
        logic tx_polarity_flip;
        logic wake_sel;
        logic idle_count_start;
        logic long_break_select;
        logic mode9;
    } asc_cfg_s;
    // Enables and software-driven requests
    typedef struct packed {
        logic rx_sleep;
        logic break_request;
        logic rx_on;
        logic tx_on;
    } asc_ctl_s;
    // Sticky status flags
    typedef struct packed {
        logic framing_error_flag;
        logic noise_flag;
        logic overrun_flag;
        logic idle_flag;
        logic rx_full_flag;
        logic tx_complete_flag;
        logic tx_empty_flag;
    } asc_sts_s;
    // Receiver sequencing
    typedef enum logic [1:0] {
        ASC_RX_HUNT,
        ASC_RX_START,
        ASC_RX_BITS
    } asc_rx_e;
endpackage : asc_pkg

// >>> tb/asc_core_assertions.sv
// Port checks on the serial core
`timescale 1ns/1ps
`default_nettype none
module asc_chk (
    input wire logic        mclk_in,     // Clock
    input wire logic        nrst_in,     // Reset
    input wire logic        psel_in,     // Select
    input wire logic        penable_in,  // Access
    input wire logic        pwrite_in,   // Direction
    input wire logic [7:0]  paddr_in,    // Address
    input wire logic [31:0] pwdata_in,   // Write data
    input wire logic [31:0] prdata_out,  // Read data
    input wire logic        pready_out,  // Ready
    input wire logic        pslverr_out, // Error
    input wire logic        rx_pin_in,   // Rx line
    input wire logic        tx_pin_out,  // Tx line
    input wire logic        tx_drive_out // Tx owns pin
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    a_ready_setup: assert property (psel_in && !penable_in |=> pready_out)
        else $error("ready missing after setup");
    a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready too long");
    a_ready_cause: assert property (pready_out |-> $past(psel_in && !penable_in))
        else $error("ready without setup");
    a_err_unmapped: assert property (psel_in && !penable_in && paddr_in > 8'h10 |=> pslverr_out)
        else $error("no error on unmapped address");
    a_err_zero: assert property (pslverr_out && !pwrite_in |-> pready_out && prdata_out == 32'h0)
        else $error("bad error read");
    a_idle_hold: assert property (!tx_drive_out && !$past(tx_drive_out) |-> $stable(tx_pin_out))
        else $error("undriven line moved");
    a_bit_width: assert property ($changed(tx_pin_out) |=> $stable(tx_pin_out)[*8])
        else $error("tx bit too short");
    a_drive_on: assert property (pready_out && pwrite_in && paddr_in == 8'h04
        && pwdata_in[0] |=> ##1 tx_drive_out) else $error("enable did not take pin");
    c_err: cover property (pslverr_out);
    c_start: cover property ($fell(tx_pin_out));
    c_drive: cover property ($rose(tx_drive_out));
endmodule : asc_chk
bind asc_core asc_chk asc_chk_i (.mclk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rx_pin_in, .tx_pin_out,
    .tx_drive_out);
`default_nettype wire

// >>> tb/asc_remote.sv
// Remote serial device: sends and receives frames
`timescale 1ns/1ps
`default_nettype none
module asc_remote #(parameter int BIT = 16) (
    input  wire logic mclk_in,  // Clock
    input  wire logic line_in,  // Device transmit line
    output logic      line_out  // Device receive line
);
    initial line_out = 1'b1;
    // Zero start, data LSB first, stop at level s (one unless a bad frame is wanted)
    task automatic send(input logic [7:0] d, input logic s = 1'b1);
        for (int i = 0; i < 10; i++) begin
            line_out <= (i == 0) ? 1'b0 : (i == 9) ? s : d[i-1];
            repeat (BIT) @(posedge mclk_in);
        end
    endtask : send
    // Wait for start, sample mid bit
    task automatic recv(output logic [7:0] d, output logic ok, output int n);
        logic st;
        n = 0;
        while (line_in !== 1'b0 && n < 4000) begin
            @(posedge mclk_in);
            n++;
        end
        repeat (BIT / 2) @(posedge mclk_in);
        st = line_in;
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge mclk_in);
            d[i] = line_in;
        end
        repeat (BIT) @(posedge mclk_in);
        ok = n < 4000 && st === 1'b0 && line_in === 1'b1;
    endtask : recv
endmodule : asc_remote
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk_in = 0, nrst_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, pslverr_out;
    logic [7:0]  paddr_in = 8'h00, d;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic pready_out, rx_pin, tx_pin_out, tx_drive_out, ok, err;
    int num_errors = 0, compares = 0, n;
    always #5 mclk_in = ~mclk_in;
    asc_core asc_core_i (.mclk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rx_pin_in(rx_pin), .tx_pin_out,
        .tx_drive_out);
    asc_remote asc_remote_i (.mclk_in, .line_in(tx_pin_out), .line_out(rx_pin));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One APB transfer, held until ready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
        int k = 0;
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= v;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            k++;
        end while (pready_out !== 1'b1 && k < 20);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge mclk_in);
        if (k >= 20) begin
            num_errors++;
            test_done();
        end
    endtask : apb
    // Poll a status bit until set
    task automatic wait_sts(input int b);
        int k = 0;
        do begin
            apb(0, 8'h08, 0);
            k++;
        end while (rd[b] !== 1'b1 && k < 200);
        chk("status poll", 1, rd[b]);
        if (k >= 200) test_done();
    endtask : wait_sts
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_tx();
        apb(1, 8'h10, 0);
        apb(1, 8'h04, 3);
        apb(1, 8'h0c, 32'ha5);
        apb(0, 8'h08, 0);
        chk("tx empty held", 0, rd[0]);
        asc_remote_i.recv(d, ok, n);
        chk("tx byte", 32'ha5, d);
        chk("tx frame", 1, ok);
        chk("preamble", 1, n > 140);
        wait_sts(1);
        chk("idle high", 1, tx_pin_out);
        apb(1, 8'h00, 32'h10);
        repeat (10) @(posedge mclk_in);
        chk("flipped idle", 0, tx_pin_out);
        apb(1, 8'h00, 0);
    endtask : t_tx
    // Break length for each format
    task automatic t_break();
        int len [4] = '{10, 11, 13, 14};
        for (int i = 0; i < 4; i++) begin
            apb(1, 8'h00, i);
            wait_sts(0);
            apb(1, 8'h04, 7);
            apb(1, 8'h04, 3);
            n = 0;
            while (tx_pin_out !== 1'b0 && n < 500) begin
                @(posedge mclk_in);
                n++;
            end
            n = 0;
            while (tx_pin_out === 1'b0 && n < 500) begin
                @(posedge mclk_in);
                n++;
            end
            chk("break clocks", len[i] * 16, n);
            wait_sts(1);
        end
        apb(1, 8'h00, 0);
    endtask : t_break
    task automatic t_rx();
        asc_remote_i.send(8'h3c);
        wait_sts(2);
        apb(0, 8'h0c, 0);
        chk("rx byte", 32'h3c, rd);
        apb(0, 8'h08, 0);
        chk("rx full cleared", 0, rd[2]);
        asc_remote_i.send(8'h55);
        asc_remote_i.send(8'haa);
        repeat (4) @(posedge mclk_in);
        apb(0, 8'h08, 0);
        chk("overrun", 1, rd[4]);
        apb(0, 8'h0c, 0);
        chk("kept byte", 32'h55, rd);
        asc_remote_i.send(8'h81, 1'b0);
        asc_remote_i.send(8'h7e);
        apb(0, 8'h08, 0);
        chk("fe flags", 32'h44, rd & 32'h74);
        apb(0, 8'h0c, 0);
        chk("fe byte", 32'h81, rd);
    endtask : t_rx
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk_in);
        nrst_in <= 1'b1;
        apb(0, 8'h08, 0);
        chk("status reset", 32'h3, rd);
        chk("tx pin reset", 1, {tx_pin_out, tx_drive_out} == 2'b10);
        apb(0, 8'h20, 0);
        chk("unmapped", 1, err === 1'b1 && rd === 32'h0);
        t_tx();
        t_break();
        t_rx();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
